// *** rtl/ftc_pkg.sv ***
// Summary of operation
// - three-bit divider select: codes 000..110 divide bus clock by 1..64, 111 external pin
// - with external clock selected the pin is forced to input
// - otherwise the external clock pin stays free for port or analog use
// - wrap flag sets when the counter returns to zero after the limit
// - wrap flag clears by read-while-set then zero write; new wrap voids it
// - wrap interrupt request follows flag and enable; reset clears the enable
// - halt bit is set by reset and freezes the counter until cleared
// - captures are blocked while the halt bit is set
// - write-only clear bit zeroes counter and prescaler, self-clears, reads zero
// - halt and clear written together leave the counter stopped at zero
// - high-byte read latches low byte; latch holds until low byte read or clear write
// - a latch taken during break survives the end of break
// - counter bytes read zero after reset or clear; writes ignored
// - the tick after the limit restarts counting from zero and sets the flag
// - limit high write blocks wrap flag and interrupt until limit low write
// - reset sets both limit registers to all ones
// - four channels capture or compare; only 0 and 2 run buffered
// - channel flag sets on active capture edge or on compare match
// - channel flag clears by read-while-set then zero write; new event voids it
// - buffered select on 0 or 2 disables the odd partner and frees its pin
// - toggle-on-wrap inverts the compare pin at each counter wrap
package ftc_pkg;
	localparam int CNT_W = 16;
	localparam int NCH = 4;
	localparam int PRE_W = 6;
	// ****************************************
	// register word indexes (byte address = 4 * index)
	// ****************************************
	localparam logic [5:0] IDX_CTRL = 6'h20;
	localparam logic [5:0] IDX_CNTH = 6'h22;
	localparam logic [5:0] IDX_CNTL = 6'h23;
	localparam logic [5:0] IDX_MODH = 6'h24;
	localparam logic [5:0] IDX_MODL = 6'h25;
	localparam logic [5:0] IDX_CHSC0 = 6'h26;
	localparam logic [5:0] IDX_CHV0 = 6'h2a;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int CTRL_FLAG = 7;
	localparam int CTRL_IE = 6;
	localparam int CTRL_HALT = 5;
	localparam int CTRL_CLR = 4;
	localparam logic [2:0] PS_EXT = 3'h7;
	// ****************************************
	// channel control fields
	// ****************************************
	localparam int CH_FLAG = 7;
	localparam int CH_IE = 6;
	localparam int CH_MSB = 5;
	localparam int CH_MSA = 4;
	localparam int CH_ELSB = 3;
	localparam int CH_ELSA = 2;
	localparam int CH_TOV = 1;
	localparam int CH_MAX = 0;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [2:0] PS_RST = 3'h0;
	localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
	localparam logic [7:0] CHSC_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
endpackage

// *** rtl/ftc_timer_top.sv ***
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ftc_timer_top (
	input wire logic clk, // 200 MHz bus clock
	input wire logic srst, // sync reset, high
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // lane 0 used
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic breakActive, // debug break state
	input wire logic extClkPin, // external count clock pin
	output logic extClkForceInput, // pin forced to input
	output logic extClkPortFree, // pin free for port/analog
	input wire logic [3:0] chPinIn, // channel pin levels
	output logic [3:0] chPinOut, // channel pin drive level
	output logic [3:0] chPinOeN, // channel drive enable, low
	output logic [3:0] chPinTimer, // timer owns the pin
	output logic wrapIrq, // wrap interrupt request
	output logic [3:0] chIrq // channel interrupt requests
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [5:0] divMask(input logic [2:0] ps);
		divMask = 6'((7'h01 << ps) - 7'h01);
	endfunction

	function automatic logic isOutMode(input logic [7:0] sc);
		isOutMode = (sc[ftc_pkg::CH_MSB] | sc[ftc_pkg::CH_MSA]) &
			(sc[ftc_pkg::CH_ELSB] | sc[ftc_pkg::CH_ELSA]);
	endfunction

	function automatic logic isCapMode(input logic [7:0] sc);
		isCapMode = ~sc[ftc_pkg::CH_MSB] & ~sc[ftc_pkg::CH_MSA] &
			(sc[ftc_pkg::CH_ELSB] | sc[ftc_pkg::CH_ELSA]);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic waitReq_ff;
	logic [31:0] rdData_ff;
	logic [2:0] psSel_ff;
	logic halt_ff, irqEn_ff, flag_ff, flagArm_ff;
	logic [ftc_pkg::PRE_W-1:0] presc_ff;
	logic [ftc_pkg::CNT_W-1:0] cnt_ff, mod_ff;
	logic modInhibit_ff;
	logic [7:0] latLow_ff;
	logic latched_ff;
	logic extS1_ff, extS2_ff, extS3_ff;
	logic [7:0] chSc_ff [ftc_pkg::NCH];
	logic [ftc_pkg::CNT_W-1:0] chVal_ff [ftc_pkg::NCH];
	logic [3:0] chArm_ff, chLock_ff, chPinPrev_ff;
	logic [1:0] bufSel_ff, lastWr_ff;
	logic [7:0] chRdVal_ff [ftc_pkg::NCH];

	// ****************************************
	// bus decode
	// ****************************************
	logic [5:0] regIdx;
	logic rdTake, wrTake;
	logic [7:0] wd;
	assign regIdx = avs_address[7:2];
	assign rdTake = avs_read & waitReq_ff;
	assign wrTake = avs_write & ~waitReq_ff & avs_byteenable[0];
	assign wd = avs_writedata[7:0];

	logic wrCtrl, rdCtrl, rdCntH, rdCntL, wrModH, wrModL;
	assign wrCtrl = wrTake & (regIdx == ftc_pkg::IDX_CTRL);
	assign rdCtrl = rdTake & (regIdx == ftc_pkg::IDX_CTRL);
	assign rdCntH = rdTake & (regIdx == ftc_pkg::IDX_CNTH);
	assign rdCntL = rdTake & (regIdx == ftc_pkg::IDX_CNTL);
	assign wrModH = wrTake & (regIdx == ftc_pkg::IDX_MODH);
	assign wrModL = wrTake & (regIdx == ftc_pkg::IDX_MODL);

	// ****************************************
	// counting
	// ****************************************
	logic presTick, countEn, clrWrite, wrap, wrapEvt, haltNow;
	logic [ftc_pkg::CNT_W-1:0] nxtCnt;
	// rising edge from the second and third sync stages
	assign presTick = (psSel_ff == ftc_pkg::PS_EXT) ? (extS2_ff & ~extS3_ff) :
		((presc_ff & divMask(psSel_ff)) == divMask(psSel_ff));
	assign clrWrite = wrCtrl & wd[ftc_pkg::CTRL_CLR];
	assign haltNow = halt_ff | breakActive;
	// step only on tick while running
	assign countEn = presTick & ~haltNow & ~clrWrite;
	assign wrap = countEn & (cnt_ff == mod_ff);
	// limit update in progress masks the flag
	assign wrapEvt = wrap & ~modInhibit_ff;
	// restart from zero after the limit
	assign nxtCnt = wrap ? ftc_pkg::CNT_ZERO : 16'(cnt_ff + 16'h0001);

	// ****************************************
	// per-channel events
	// ****************************************
	logic [3:0] chOff, capEvt, cmpEvt, chWrSc, chRdSc, chWrH, chWrL, chRdH, chRdL;
	logic [ftc_pkg::CNT_W-1:0] actVal [ftc_pkg::NCH];
	always_comb begin
		for (int i = 0; i < ftc_pkg::NCH; i++) begin
			// odd partner disabled by buffered select
			chOff[i] = (i % 2 == 1) && chSc_ff[i-(i%2)][ftc_pkg::CH_MSB];
			chWrSc[i] = wrTake & (regIdx == 6'(ftc_pkg::IDX_CHSC0 + 6'(i))) & ~chOff[i];
			chRdSc[i] = rdTake & (regIdx == 6'(ftc_pkg::IDX_CHSC0 + 6'(i)));
			chWrH[i] = wrTake & (regIdx == 6'(ftc_pkg::IDX_CHV0 + 6'(2 * i)));
			chWrL[i] = wrTake & (regIdx == 6'(ftc_pkg::IDX_CHV0 + 6'(2 * i + 1)));
			chRdH[i] = rdTake & (regIdx == 6'(ftc_pkg::IDX_CHV0 + 6'(2 * i)));
			chRdL[i] = rdTake & (regIdx == 6'(ftc_pkg::IDX_CHV0 + 6'(2 * i + 1)));
			actVal[i] = chVal_ff[i];
			if ((i % 2 == 0) && chSc_ff[i][ftc_pkg::CH_MSB] && bufSel_ff[i/2])
				actVal[i] = chVal_ff[i+1];
			// no capture while halted or in break
			capEvt[i] = isCapMode(chSc_ff[i]) & ~chOff[i] & ~haltNow & ~chLock_ff[i] &
				((chSc_ff[i][ftc_pkg::CH_ELSA] & chPinIn[i] & ~chPinPrev_ff[i]) |
				(chSc_ff[i][ftc_pkg::CH_ELSB] & ~chPinIn[i] & chPinPrev_ff[i]));
			// buffered compare only on even channels
			// compare match as the counter reaches the value
			cmpEvt[i] = isOutMode(chSc_ff[i]) & ~chOff[i] & ~chLock_ff[i] & countEn &
				(nxtCnt == actVal[i]) &
				((i % 2 == 0) | ~chSc_ff[i][ftc_pkg::CH_MSB]);
		end
	end

	// ****************************************
	// bus handshake: one wait cycle per access
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			waitReq_ff <= 1'b1;
		end else if ((avs_read | avs_write) & waitReq_ff) begin
			waitReq_ff <= 1'b0;
		end else begin
			waitReq_ff <= 1'b1;
		end
	end

	// ****************************************
	// read data mux
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_ff <= 32'h0000_0000;
		end else if (rdTake) begin
			rdData_ff <= 32'h0000_0000;
			unique case (regIdx)
				ftc_pkg::IDX_CTRL: rdData_ff[7:0] <= {flag_ff, irqEn_ff, halt_ff,
					1'b0, 1'b0, psSel_ff};
				// counter bytes from live counter or latch
				ftc_pkg::IDX_CNTH: rdData_ff[7:0] <= cnt_ff[15:8];
				// low byte from latch while latched
				ftc_pkg::IDX_CNTL: rdData_ff[7:0] <= latched_ff ? latLow_ff : cnt_ff[7:0];
				ftc_pkg::IDX_MODH: rdData_ff[7:0] <= mod_ff[15:8];
				ftc_pkg::IDX_MODL: rdData_ff[7:0] <= mod_ff[7:0];
				default: begin
					for (int i = 0; i < ftc_pkg::NCH; i++) begin
						if (chRdSc[i])
							rdData_ff[7:0] <= chOff[i] ? 8'h00 : chSc_ff[i];
						if (chRdH[i])
							rdData_ff[7:0] <= chVal_ff[i][15:8];
						if (chRdL[i])
							rdData_ff[7:0] <= chVal_ff[i][7:0];
					end
				end
			endcase
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			psSel_ff <= ftc_pkg::PS_RST;
			irqEn_ff <= 1'b0;
			halt_ff <= 1'b1;
		end else if (wrCtrl) begin
			psSel_ff <= wd[2:0];
			irqEn_ff <= wd[ftc_pkg::CTRL_IE];
			halt_ff <= wd[ftc_pkg::CTRL_HALT];
		end
	end

	// ****************************************
	// wrap flag with two-step clear
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_ff <= 1'b0;
			flagArm_ff <= 1'b0;
		end else begin
			// set on wrap, set beats clear
			if (wrapEvt) begin
				flag_ff <= 1'b1;
				flagArm_ff <= 1'b0;
			end else if (rdCtrl & flag_ff) begin
				flagArm_ff <= 1'b1;
			end else if (wrCtrl) begin
				// zero write clears only when armed
				if (flagArm_ff & ~wd[ftc_pkg::CTRL_FLAG])
					flag_ff <= 1'b0;
				flagArm_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// prescaler, counter, external sync
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			presc_ff <= '0;
			cnt_ff <= ftc_pkg::CNT_ZERO;
		end else if (clrWrite) begin
			presc_ff <= '0;
			cnt_ff <= ftc_pkg::CNT_ZERO;
		end else begin
			if (~haltNow)
				presc_ff <= 6'(presc_ff + 6'h01);
			if (countEn)
				cnt_ff <= nxtCnt;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			extS1_ff <= 1'b0;
			extS2_ff <= 1'b0;
			extS3_ff <= 1'b0;
		end else begin
			extS1_ff <= extClkPin;
			extS2_ff <= extS1_ff;
			extS3_ff <= extS2_ff;
		end
	end

	// ****************************************
	// low byte latch
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst | clrWrite) begin
			latched_ff <= 1'b0;
			latLow_ff <= 8'h00;
		end else if (rdCntH & ~latched_ff) begin
			// first high read latches the low byte
			latched_ff <= 1'b1;
			latLow_ff <= cnt_ff[7:0];
		end else if (rdCntL) begin
			latched_ff <= 1'b0;
		end
	end

	// ****************************************
	// wrap limit registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			mod_ff <= ftc_pkg::MOD_RST;
			modInhibit_ff <= 1'b0;
		end else if (wrModH) begin
			// block wrap flag until low byte written
			mod_ff[15:8] <= wd;
			modInhibit_ff <= 1'b1;
		end else if (wrModL) begin
			mod_ff[7:0] <= wd;
			modInhibit_ff <= 1'b0;
		end
	end

	// ****************************************
	// channel control, flags, values
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			chArm_ff <= 4'h0;
			chLock_ff <= 4'h0;
			chPinPrev_ff <= 4'h0;
			bufSel_ff <= 2'h0;
			lastWr_ff <= 2'h0;
			for (int i = 0; i < ftc_pkg::NCH; i++) begin
				chSc_ff[i] <= ftc_pkg::CHSC_RST;
				chVal_ff[i] <= ftc_pkg::CNT_ZERO;
			end
		end else begin
			chPinPrev_ff <= chPinIn;
			for (int i = 0; i < ftc_pkg::NCH; i++) begin
				if (chWrSc[i]) begin
					chSc_ff[i][6:0] <= wd[6:0];
					if (i % 2 == 1)
						chSc_ff[i][ftc_pkg::CH_MSB] <= 1'b0;
				end
				// set beats the armed zero write
				if (capEvt[i] | cmpEvt[i]) begin
					chSc_ff[i][ftc_pkg::CH_FLAG] <= 1'b1;
					chArm_ff[i] <= 1'b0;
				end else if (chRdSc[i] & chSc_ff[i][ftc_pkg::CH_FLAG]) begin
					chArm_ff[i] <= 1'b1;
				end else if (chWrSc[i]) begin
					if (chArm_ff[i] & ~wd[ftc_pkg::CH_FLAG])
						chSc_ff[i][ftc_pkg::CH_FLAG] <= 1'b0;
					chArm_ff[i] <= 1'b0;
				end
				if (capEvt[i])
					chVal_ff[i] <= cnt_ff;
				if (chWrH[i])
					chVal_ff[i][15:8] <= wd;
				if (chWrL[i])
					chVal_ff[i][7:0] <= wd;
				// high access locks capture or compare until low access
				if (chRdH[i] & isCapMode(chSc_ff[i]))
					chLock_ff[i] <= 1'b1;
				else if (chWrH[i] & ~isCapMode(chSc_ff[i]))
					chLock_ff[i] <= 1'b1;
				else if (chRdL[i] | chWrL[i])
					chLock_ff[i] <= 1'b0;
			end
			for (int p = 0; p < 2; p++) begin
				if (chWrL[2*p] | chWrH[2*p])
					lastWr_ff[p] <= 1'b0;
				if (chWrL[2*p+1] | chWrH[2*p+1])
					lastWr_ff[p] <= 1'b1;
				if (wrap)
					bufSel_ff[p] <= lastWr_ff[p];
			end
		end
	end

	// ****************************************
	// channel pin drive
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			chPinOut <= 4'h0;
			chPinOeN <= 4'hf;
			chPinTimer <= 4'h0;
		end else begin
			for (int i = 0; i < ftc_pkg::NCH; i++) begin
				chPinTimer[i] <= ~chOff[i] &
					(chSc_ff[i][ftc_pkg::CH_ELSB] | chSc_ff[i][ftc_pkg::CH_ELSA]);
				chPinOeN[i] <= ~(isOutMode(chSc_ff[i]) & ~chOff[i]);
				if (~(chSc_ff[i][ftc_pkg::CH_ELSB] | chSc_ff[i][ftc_pkg::CH_ELSA])) begin
					// preset level: select A low gives high
					chPinOut[i] <= ~chSc_ff[i][ftc_pkg::CH_MSA];
				end else if (isOutMode(chSc_ff[i]) & ~chOff[i]) begin
					if (chSc_ff[i][ftc_pkg::CH_TOV] & wrap)
						chPinOut[i] <= ~chPinOut[i];
					else if (chSc_ff[i][ftc_pkg::CH_MAX] & ~chSc_ff[i][ftc_pkg::CH_TOV])
						chPinOut[i] <= chSc_ff[i][ftc_pkg::CH_ELSB] &
							~chSc_ff[i][ftc_pkg::CH_ELSA];
					else if (cmpEvt[i])
						chPinOut[i] <= chSc_ff[i][ftc_pkg::CH_ELSA] ?
							(chSc_ff[i][ftc_pkg::CH_ELSB] | ~chPinOut[i]) : 1'b0;
				end
			end
		end
	end

	// ****************************************
	// interrupt requests and clock pin role
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			wrapIrq <= 1'b0;
			chIrq <= 4'h0;
			extClkForceInput <= 1'b0;
			extClkPortFree <= 1'b1;
		end else begin
			wrapIrq <= flag_ff & irqEn_ff;
			for (int i = 0; i < ftc_pkg::NCH; i++)
				chIrq[i] <= chSc_ff[i][ftc_pkg::CH_FLAG] & chSc_ff[i][ftc_pkg::CH_IE] & ~chOff[i];
			// force input when counting the pin
			extClkForceInput <= (psSel_ff == ftc_pkg::PS_EXT);
			// otherwise leave pin to port or analog use
			extClkPortFree <= (psSel_ff != ftc_pkg::PS_EXT);
		end
	end

	assign avs_readdata = rdData_ff;
	assign avs_waitrequest = waitReq_ff;
endmodule
`default_nettype wire

// *** verif/ftc_timer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module ftc_timer_assertions (
	input wire logic clk, // bus clock
	input wire logic srst, // sync reset
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic extClkForceInput, // pin forced in
	input wire logic extClkPortFree, // pin free
	input wire logic [3:0] chPinOeN, // drive enable low
	input wire logic wrapIrq, // wrap request
	input wire logic [3:0] chIrq // channel requests
);
	logic [1:0] wrTake_ff;
	logic rstD_ff;
	logic ctlRd_ff;
	// taken writes two deep: a write lands, the registered output moves one edge later
	always_ff @(posedge clk) begin
		wrTake_ff <= {wrTake_ff[0], avs_write & ~avs_waitrequest};
		rstD_ff <= srst;
		ctlRd_ff <= avs_read & avs_waitrequest & (avs_address[7:2] == ftc_pkg::IDX_CTRL);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence reqSeen;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence ackOnce;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	bus_ack_a: assert property (reqSeen |=> ackOnce)
		else $error("bus answer late or long");
	pin_excl_a: assert property (extClkForceInput != extClkPortFree)
		else $error("clock pin roles overlap");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	clr_reads0_a: assert property (ctlRd_ff |-> !avs_waitrequest && !avs_readdata[4])
		else $error("clear bit reads one");
	reset_out_a: assert property (rstD_ff |-> avs_waitrequest && !wrapIrq && chIrq == 4'h0
		&& chPinOeN == 4'hf && extClkPortFree)
		else $error("outputs wrong after reset");
	wrap_fall_a: assert property (!rstD_ff && $fell(wrapIrq) |-> wrTake_ff[1])
		else $error("wrap request dropped without write");
	ext_sel_a: assert property (!rstD_ff && $changed(extClkForceInput) |-> wrTake_ff[1])
		else $error("clock pin role changed without write");
	ch_fall_a: assert property (!rstD_ff && |($past(chIrq) & ~chIrq) |-> wrTake_ff[1])
		else $error("channel request dropped without write");
	rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
endmodule
bind ftc_timer_top ftc_timer_assertions ftc_timer_assertions_inst (.clk, .srst, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .extClkForceInput, .extClkPortFree,
	.chPinOeN, .wrapIrq, .chIrq);
`default_nettype wire

// *** verif/ftc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// clock source and channel pins
// ****
module ftc_pin_model (
	input wire logic clk, // bus clock
	input wire logic extRun, // external clock runs
	input wire logic [3:0] pulseReq, // toggle pin level
	input wire logic [3:0] chPinOut, // device level
	input wire logic [3:0] chPinOeN, // device enable, low
	output logic extClkPin, // external count clock
	output logic [3:0] chPinIn // resolved pin level
);
	int div = 0;
	logic [3:0] drv = 4'h0;
	initial extClkPin = 1'b0;
	always @(posedge clk) begin
		if (!extRun) begin
			div <= 0;
			extClkPin <= 1'b0;
		end else if (div == 24) begin
			div <= 0;
			extClkPin <= ~extClkPin;
		end else
			div <= div + 1;
	end
	// far side edges on request
	always @(posedge clk)
		drv <= drv ^ pulseReq;
	// wire level from both enables
	assign chPinIn = (chPinOut & ~chPinOeN) | (drv & chPinOeN);
endmodule
`default_nettype wire

// *** verif/ftc_timer_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ftc_timer_top_bench;
	logic clk;
	logic srst;
	logic [7:0] addr;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic waitReq;
	logic brk;
	logic extClk;
	logic extRun;
	logic [3:0] pulse;
	logic forceIn;
	logic portFree;
	logic [3:0] pinIn;
	logic [3:0] pinOut;
	logic [3:0] pinOeN;
	logic [3:0] pinTimer;
	logic [3:0] chIrq;
	logic wrapIrq;
	logic [7:0] q;
	logic [7:0] q1;
	logic prv;
	int badCount = 0;
	int checked = 0;
	int lim;
	int tg;
	logic [5:0] idxQ[$] = '{6'h20, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h3f};
	logic [7:0] expQ[$] = '{8'h20, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	ftc_timer_top ftc_timer_top_inst (.clk(clk), .srst(srst), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1), .avs_readdata(rdata),
		.avs_waitrequest(waitReq), .breakActive(brk), .extClkPin(extClk),
		.extClkForceInput(forceIn), .extClkPortFree(portFree), .chPinIn(pinIn),
		.chPinOut(pinOut), .chPinOeN(pinOeN), .chPinTimer(pinTimer), .wrapIrq(wrapIrq),
		.chIrq(chIrq));
	ftc_pin_model ftc_pin_model_inst (.clk(clk), .extRun(extRun), .pulseReq(pulse),
		.chPinOut(pinOut), .chPinOeN(pinOeN), .extClkPin(extClk), .chPinIn(pinIn));
	// ****
	// clock and tasks
	// ****
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// one access, held until waitrequest low
	task automatic busOp(input logic w, input logic [5:0] ix, input logic [7:0] d);
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= {ix, 2'b00};
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (waitReq !== 1'b0);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			badCount++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdChk(input logic [5:0] ix, input logic [7:0] e);
		busOp(1'b0, ix, 8'h00);
		chk($sformatf("reg%h", ix), e, q);
	endtask
	task automatic wrReg(input logic [5:0] ix, input logic [7:0] d);
		busOp(1'b1, ix, d);
	endtask
	task automatic giveVerdict();
		if (badCount == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (60000) @(posedge clk);
		badCount++;
		giveVerdict();
	end
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(32'h1b3f));
		{srst, rd, wr, addr, wdata, brk, extRun, pulse} = {1'b1, 48'h0};
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		foreach (idxQ[i]) rdChk(idxQ[i], expQ[i]);
		wrReg(6'h22, 8'h5a);
		rdChk(6'h22, 8'h00);
		lim = 6 + $urandom % 10;
		wrReg(6'h24, 8'h00);
		wrReg(6'h25, 8'(lim));
		// divider codes, about four ticks each
		for (int p = 1; p < 7; p++) begin
			wrReg(6'h20, 8'(8'h30 | p));
			wrReg(6'h20, 8'(p));
			repeat (4 << p) @(posedge clk);
			wrReg(6'h20, 8'(8'h20 | p));
			busOp(1'b0, 6'h23, 8'h00);
			chk("ticks", 8'h01, 8'(q >= 4 && q <= 6));
		end
		wrReg(6'h20, 8'h70);
		wrReg(6'h20, 8'h40);
		repeat (40) @(posedge clk);
		chk("wrapIrq", 8'h01, 8'(wrapIrq));
		busOp(1'b0, 6'h23, 8'h00);
		chk("inRange", 8'h01, 8'(q <= lim));
		rdChk(6'h20, 8'hc0);
		// wraps in between void the armed clear
		repeat (40) @(posedge clk);
		wrReg(6'h20, 8'h60);
		rdChk(6'h20, 8'he0);
		wrReg(6'h20, 8'h60);
		rdChk(6'h20, 8'h60);
		chk("wrapIrq", 8'h00, 8'(wrapIrq));
		wrReg(6'h20, 8'he0);
		rdChk(6'h20, 8'h60);
		// clear the counter before touching the limit
		wrReg(6'h20, 8'h70);
		wrReg(6'h24, 8'h00);
		wrReg(6'h20, 8'h40);
		repeat (40) @(posedge clk);
		rdChk(6'h20, 8'h40);
		wrReg(6'h20, 8'h70);
		wrReg(6'h25, 8'(lim));
		wrReg(6'h20, 8'h40);
		repeat (40) @(posedge clk);
		// halt first so no wrap can disarm the clear below
		wrReg(6'h20, 8'he0);
		rdChk(6'h20, 8'he0);
		wrReg(6'h20, 8'h70);
		rdChk(6'h23, 8'h00);
		rdChk(6'h20, 8'h60);
		rdChk(6'h25, 8'(lim));
		// latch taken in break
		wrReg(6'h20, 8'h00);
		brk <= 1'b1;
		rdChk(6'h22, 8'h00);
		busOp(1'b0, 6'h23, 8'h00);
		q1 = q;
		rdChk(6'h22, 8'h00);
		brk <= 1'b0;
		repeat (3 * lim) @(posedge clk);
		rdChk(6'h23, q1);
		// external clock, five rising edges; pin role is registered
		wrReg(6'h20, 8'h37);
		repeat (2) @(posedge clk);
		chk("forceIn", 8'h02, 8'({forceIn, portFree}));
		wrReg(6'h20, 8'h07);
		extRun <= 1'b1;
		repeat (250) @(posedge clk);
		extRun <= 1'b0;
		rdChk(6'h23, 8'h05);
		wrReg(6'h20, 8'h30);
		repeat (2) @(posedge clk);
		chk("portFree", 8'h01, 8'({forceIn, portFree}));
		// capture on either edge: halted rising blocked, running falling taken
		for (int c = 0; c < 4; c++) begin
			wrReg(6'(6'h26 + c), 8'h4c);
			pulse <= 4'(1 << c);
			@(posedge clk);
			pulse <= 4'h0;
			repeat (8) @(posedge clk);
			rdChk(6'(6'h26 + c), 8'h4c);
			wrReg(6'h20, 8'h00);
			pulse <= 4'(1 << c);
			@(posedge clk);
			pulse <= 4'h0;
			repeat (8) @(posedge clk);
			rdChk(6'(6'h26 + c), 8'hcc);
			chk("chIrq", 8'h03, 8'({chIrq[c], pinTimer[c]}));
			wrReg(6'(6'h26 + c), 8'h4c);
			rdChk(6'(6'h26 + c), 8'h4c);
			wrReg(6'h20, 8'h20);
		end
		// buffered pair frees the odd pin
		wrReg(6'h26, 8'h28);
		rdChk(6'h27, 8'h00);
		wrReg(6'h27, 8'h44);
		rdChk(6'h27, 8'h00);
		chk("pins", 8'h00, 8'({pinTimer[1], pinOeN[0]}));
		// toggle on every wrap; compare value zero meets only the wrap
		wrReg(6'h28, 8'h16);
		wrReg(6'h2e, 8'h00);
		wrReg(6'h2f, 8'h00);
		wrReg(6'h20, 8'h00);
		tg = 0;
		prv = pinOut[2];
		repeat (20 * (lim + 1)) begin
			@(posedge clk);
			tg += int'(pinOut[2] !== prv);
			prv = pinOut[2];
		end
		chk("toggles", 8'h01, 8'(tg >= 19 && tg <= 21 && pinOeN[2] === 1'b0));
		giveVerdict();
	end
endmodule
`default_nettype wire
